//--- logic/rx_regs.sv
// Purpose: Register file and RAM map of a digital receive processor, two control ports
// Assumes: Both port protocols already reduced to request strobes synchronous to ref_clk_i
// Notes: Serial port has priority; parallel port stalls by ready or acknowledge
//
// Summary of operation
// R1: All registers and RAMs reachable from both ports, ports usable concurrently.
// R2: Serial port wins simultaneous requests, even against a parallel cycle already waiting.
// R3: Handshake mode 0: ready held low while a serial access is pending.
// R4: Handshake mode 1: acknowledge withheld until serial access completes.
// R5: Coefficient memory holds 256 words of 20 bits at bottom of map.
// R6: Two-channel real mode limits filter length to 128 taps per channel.
// R7: Tap count comes only from the tap-count-minus-one register.
// R8: Data memory word keeps in-phase low 18 bits, quadrature high 18 bits.
// R9: Data memory is port readable and writable and never cleared by reset.
// R10: Reset sets mode bit 0, holding soft reset until software clears it.
// R11: Reset clears sync-role bit, device comes up as sync slave.
// R12: Mode decoded from bits 2 and 1 when soft reset is clear.
// R13: Mode bit 3 high drives sync pins out; low makes them inputs.
// R14: Software writes zeros to upper four mode bits.
// R15: Oscillator bypass gives identical untranslated I and Q, input down 12 dB.
// R16: Phase dither and amplitude dither enables act independently.
// R17: Sync-mask write loads shadow; read returns the active mask.
// R18: Tuning word is 32-bit unsigned, phase offset 16 bits.
// R19: Stage-2 shift field is unsigned 0 to 6, larger shifts further down.
// R20: Exponent direction bit picks shift down or up as exponent rises.
// R21: Exponent offset bits 7 to 5 add gain to incoming data.
// R22: Three decimation registers hold rate minus one as 8 bits.
// R23: Soft reset ignores input, stops processing, idles outputs, forces sync slave.
// R24: Reserved bits and addresses ignore writes and read zero.
`timescale 1ns/100ps
`include "rx_regs_cfg.svh"
module rx_regs
    import rx_regs_pkg::*;
#(
    parameter int COEF_DEPTH = 256,
    parameter int DRAM_DEPTH = 256
)
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Parallel port: handshake mode, request, answer
    input wire logic par_mode1_i,
    input wire ctl_req_s par_req_i,
    output logic par_ready_o,
    output logic transfer_acknowledge_o,
    output logic [35:0] par_rdata_o,
    // Serial port: request, answer
    input wire ctl_req_s ser_req_i,
    output logic ser_done_o,
    output logic [35:0] ser_rdata_o,
    // Datapath side
    input wire logic [35:0] fir_data_i,
    input wire logic fir_data_we_i,
    input wire logic [7:0] fir_data_addr_i,
    input wire logic [7:0] fir_coef_addr_i,
    output logic [`COEF_W-1:0] fir_coef_o,
    input wire logic sync_mask_load_i,
    output dsp_cfg_s cfg_o,
    output logic [31:0] sync_mask_o,
    output logic [31:0] tuning_word_o,
    output logic [15:0] phase_offset_o,
    output logic [7:0] stage2_decimation_o,
    output logic [7:0] stage5_decimation_o,
    output logic [7:0] fir_decimation_o,
    output logic [7:0] coefficient_base_o,
    output logic [3:0] output_filter_control_o,
    // Sync pin drive enable and input gate
    output logic sync_pins_oe_o,
    output logic input_enable_o
);
    // Offsets are 8 bits, so only 256-deep memories decode cleanly
    if (COEF_DEPTH != 256 || DRAM_DEPTH != 256)
    begin
        $error("rx_regs: memories must be 256 deep to match the 8-bit offsets");
    end

    // Memories: no reset on either, contents survive soft and hard reset
    logic [`COEF_W-1:0] coef_mem [COEF_DEPTH];
    logic [35:0] data_mem [DRAM_DEPTH];

    logic [7:0] mode_q;
    logic [2:0] osc_q;
    logic [31:0] mask_shadow_q, mask_active_q;
    logic [31:0] tuning_q;
    logic [15:0] phase_q;
    logic [7:0] in_scale_q, s2_dec_q, s5_dec_q, fir_dec_q, coef_base_q, tap_q;
    logic [4:0] s5_scale_q;
    logic [3:0] out_ctl_q;
    par_state_e par_q;

    // Port arbitration
    // Serial never waits; a started parallel cycle only finishes in its ack phase
    wire ser_go = ser_req_i.req; // R2
    wire par_go = par_q == P_WAIT && !ser_req_i.req; // R2
    wire ctl_req_s acc = ser_go ? ser_req_i : par_req_i;
    wire acc_go = ser_go || par_go;
    wire acc_wr = acc_go && acc.wr;

    function automatic logic in_range(input logic [`ADDR_W-1:0] a,
                                      input logic [`ADDR_W-1:0] lo,
                                      input logic [`ADDR_W-1:0] hi);
        in_range = a >= lo && a <= hi;
    endfunction

    wire hit_coef = in_range(acc.addr, `COEF_LO, `COEF_HI); // R5
    wire hit_dram = in_range(acc.addr, `DRAM_LO, `DRAM_HI);
    wire [7:0] mem_idx = acc.addr[7:0];

    logic [35:0] rdata;
    always_comb
    begin
        rdata = 36'h0; // R24
        if (hit_coef)
            rdata = {16'h0, coef_mem[mem_idx]};
        else if (hit_dram)
            rdata = data_mem[mem_idx]; // R8
        else if (acc.addr == `OFF_MODE)
            rdata = {32'h0, mode_q[3:0]};
        else if (acc.addr == `OFF_OSC)
            rdata = {33'h0, osc_q};
        else if (acc.addr == `OFF_SYNC_MASK)
            rdata = {4'h0, mask_active_q}; // R17
        else if (acc.addr == `OFF_TUNING)
            rdata = {4'h0, tuning_q};
        else if (acc.addr == `OFF_PHASE)
            rdata = {20'h0, phase_q};
        else if (acc.addr == `OFF_IN_SCALE)
            rdata = {28'h0, in_scale_q[7:4], 1'b0, in_scale_q[2:0]};
        else if (acc.addr == `OFF_S2_DEC)
            rdata = {28'h0, s2_dec_q};
        else if (acc.addr == `OFF_S5_SCALE)
            rdata = {31'h0, s5_scale_q};
        else if (acc.addr == `OFF_S5_DEC)
            rdata = {28'h0, s5_dec_q};
        else if (acc.addr == `OFF_OUT_CTL)
            rdata = {32'h0, out_ctl_q};
        else if (acc.addr == `OFF_FIR_DEC)
            rdata = {28'h0, fir_dec_q};
        else if (acc.addr == `OFF_COEF_BASE)
            rdata = {28'h0, coef_base_q};
        else if (acc.addr == `OFF_TAP_COUNT)
            rdata = {28'h0, tap_q};
    end

    // Memory writes; datapath data writes yield to the control ports
    always_ff @(posedge ref_clk_i)
    begin
        if (acc_wr && hit_coef)
            coef_mem[mem_idx] <= acc.wdata[`COEF_W-1:0];
        fir_coef_o <= coef_mem[fir_coef_addr_i];
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (acc_wr && hit_dram)
            data_mem[mem_idx] <= acc.wdata; // R9
        else if (fir_data_we_i && !mode_q[`MODE_SOFT_RESET])
            data_mem[fir_data_addr_i] <= fir_data_i;
    end

    function automatic logic wr_to(input logic [`ADDR_W-1:0] off);
        wr_to = acc_wr && acc.addr == off;
    endfunction

    // Register writes; reserved bits are simply not stored
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= `MODE_RESET; // R10 R11
            osc_q <= 3'h0;
            mask_shadow_q <= 32'h0;
            mask_active_q <= 32'h0;
            tuning_q <= 32'h0;
            phase_q <= 16'h0;
            in_scale_q <= 8'h0;
            s2_dec_q <= 8'h0;
            s5_scale_q <= 5'h0;
            s5_dec_q <= 8'h0;
            out_ctl_q <= 4'h0;
            fir_dec_q <= 8'h0;
            coef_base_q <= 8'h0;
            tap_q <= 8'h0;
        end
        else
        begin
            if (wr_to(`OFF_MODE))
                mode_q <= {4'h0, acc.wdata[3:0]}; // R14 R24
            if (wr_to(`OFF_OSC))
                osc_q <= acc.wdata[2:0]; // R16
            if (wr_to(`OFF_SYNC_MASK))
                mask_shadow_q <= acc.wdata[31:0]; // R17
            if (sync_mask_load_i)
                mask_active_q <= mask_shadow_q; // R17
            if (wr_to(`OFF_TUNING))
                tuning_q <= acc.wdata[31:0]; // R18
            if (wr_to(`OFF_PHASE))
                phase_q <= acc.wdata[15:0]; // R18
            if (wr_to(`OFF_IN_SCALE))
                in_scale_q <= {acc.wdata[7:4], 1'b0, acc.wdata[2:0]};
            if (wr_to(`OFF_S2_DEC))
                s2_dec_q <= acc.wdata[7:0]; // R22
            if (wr_to(`OFF_S5_SCALE))
                s5_scale_q <= acc.wdata[4:0];
            if (wr_to(`OFF_S5_DEC))
                s5_dec_q <= acc.wdata[7:0]; // R22
            if (wr_to(`OFF_OUT_CTL))
                out_ctl_q <= acc.wdata[3:0];
            if (wr_to(`OFF_FIR_DEC))
                fir_dec_q <= acc.wdata[7:0]; // R22
            if (wr_to(`OFF_COEF_BASE))
                coef_base_q <= acc.wdata[7:0];
            if (wr_to(`OFF_TAP_COUNT))
                tap_q <= acc.wdata[7:0]; // R7
        end
    end

    // Parallel cycle: a started cycle waits in P_WAIT while serial requests; only P_ACK ignores serial
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            par_q <= P_IDLE;
        end
        else
        begin
            case (par_q)
                P_IDLE:
                    if (par_req_i.req)
                        par_q <= P_WAIT;
                P_WAIT:
                    if (par_go)
                        par_q <= P_ACK;
                P_ACK:
                    if (!par_req_i.req)
                        par_q <= P_IDLE;
                default:
                    par_q <= P_IDLE;
            endcase
        end
    end

    // Port answers
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            par_ready_o <= 1'b1;
            transfer_acknowledge_o <= 1'b0;
            par_rdata_o <= 36'h0;
            ser_done_o <= 1'b0;
            ser_rdata_o <= 36'h0;
        end
        else
        begin
            par_ready_o <= !par_mode1_i && !(ser_req_i.req && par_q != P_ACK) // R3
                && !(par_q == P_IDLE && par_req_i.req) && !par_go;
            transfer_acknowledge_o <= par_mode1_i && (par_go || // R4
                (par_q == P_ACK && par_req_i.req));
            if (par_go)
                par_rdata_o <= rdata;
            ser_done_o <= ser_go; // R1
            if (ser_go)
                ser_rdata_o <= rdata;
        end
    end

    // Configuration decode for the datapath
    wire soft_rst = mode_q[`MODE_SOFT_RESET];
    op_mode_e mode_dec;
    assign mode_dec = soft_rst ? MODE_HALTED : // R12
        (mode_q[`MODE_COMPLEX] ? MODE_SINGLE_COMPLEX :
        (mode_q[`MODE_DIVERSITY] ? MODE_DIVERSITY_REAL : MODE_SINGLE_REAL));
    wire [8:0] taps_full = {1'b0, tap_q} + 9'h001; // R7
    wire [8:0] taps_lim = (mode_dec == MODE_DIVERSITY_REAL && taps_full > `DIVERSITY_TAPS)
        ? `DIVERSITY_TAPS : taps_full; // R6
    wire [2:0] s2_sat = in_scale_q[2:0] > `S2_SHIFT_MAX ? `S2_SHIFT_MAX : in_scale_q[2:0];

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            cfg_o <= '{mode: MODE_HALTED, soft_reset: 1'b1, default: '0};
            sync_pins_oe_o <= 1'b0;
            input_enable_o <= 1'b0;
        end
        else
        begin
            cfg_o.mode <= mode_dec;
            cfg_o.soft_reset <= soft_rst; // R23
            cfg_o.sync_master <= mode_q[`MODE_SYNC_MASTER] && !soft_rst; // R13 R23
            cfg_o.osc_bypass <= osc_q[`OSC_BYPASS]; // R15
            cfg_o.phase_dither <= osc_q[`OSC_PHASE_DITHER]; // R16
            cfg_o.amp_dither <= osc_q[`OSC_AMP_DITHER]; // R16
            cfg_o.exponent_direction <= in_scale_q[`IN_EXP_DIR]; // R20
            cfg_o.exponent_gain_offset <= in_scale_q[7:`IN_GAIN_LSB]; // R21
            cfg_o.stage2_shift <= s2_sat; // R19
            cfg_o.stage5_shift <= s5_scale_q;
            cfg_o.taps <= taps_lim;
            sync_pins_oe_o <= mode_q[`MODE_SYNC_MASTER] && !soft_rst; // R13
            input_enable_o <= !soft_rst; // R23
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        sync_mask_o <= mask_active_q;
        tuning_word_o <= tuning_q;
        phase_offset_o <= phase_q;
        stage2_decimation_o <= s2_dec_q;
        stage5_decimation_o <= s5_dec_q;
        fir_decimation_o <= fir_dec_q;
        coefficient_base_o <= coef_base_q;
        output_filter_control_o <= out_ctl_q;
    end

    // Checks
    property p_reset_mode;
        @(posedge ref_clk_i) rst_i |=> mode_q == `MODE_RESET;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not reset"); // R10

    property p_slave_after_reset;
        @(posedge ref_clk_i) rst_i ##1 rst_i |=> !sync_pins_oe_o;
    endproperty
    a_slave_after_reset: assert property (p_slave_after_reset) else $error("sync oe"); // R11

    property p_ser_first;
        @(posedge ref_clk_i) disable iff (rst_i)
            ser_req_i.req && par_q == P_WAIT |=> ser_done_o && par_q == P_WAIT;
    endproperty
    a_ser_first: assert property (p_ser_first) else $error("serial lost"); // R2

    property p_ready_low;
        @(posedge ref_clk_i) disable iff (rst_i)
            !par_mode1_i && ser_req_i.req && par_q == P_WAIT |=> !par_ready_o;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready high"); // R3

    property p_ack_held;
        @(posedge ref_clk_i) disable iff (rst_i)
            ser_req_i.req && par_q == P_WAIT |=> !transfer_acknowledge_o;
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack early"); // R4

    property p_mask_read;
        @(posedge ref_clk_i) disable iff (rst_i)
            ser_go && acc.addr == `OFF_SYNC_MASK |=> ser_rdata_o[31:0] == $past(mask_active_q);
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read"); // R17

    property p_div_taps;
        @(posedge ref_clk_i) disable iff (rst_i)
            mode_dec == MODE_DIVERSITY_REAL |=> cfg_o.taps <= `DIVERSITY_TAPS;
    endproperty
    a_div_taps: assert property (p_div_taps) else $error("taps over"); // R6

    property p_soft_idle;
        @(posedge ref_clk_i) disable iff (rst_i)
            soft_rst |=> !input_enable_o && !sync_pins_oe_o;
    endproperty
    a_soft_idle: assert property (p_soft_idle) else $error("soft reset active"); // R23

    property p_s2_range;
        @(posedge ref_clk_i) disable iff (rst_i) cfg_o.stage2_shift <= `S2_SHIFT_MAX;
    endproperty
    a_s2_range: assert property (p_s2_range) else $error("shift range"); // R19

    property p_rsvd_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
            par_go && acc.addr == `OFF_RSVD |=> par_rdata_o == 36'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read"); // R24
endmodule

//--- logic/rx_regs_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the receiver register map
// Assumes: Word addresses of 10 bits as seen on both control ports
// Notes: Definitions only
`ifndef RX_REGS_CFG_SVH
`define RX_REGS_CFG_SVH
`define ADDR_W 10
`define COEF_LO 10'h000
`define COEF_HI 10'h0ff
`define DRAM_LO 10'h100
`define DRAM_HI 10'h1ff
`define OFF_MODE 10'h300
`define OFF_OSC 10'h301
`define OFF_SYNC_MASK 10'h302
`define OFF_TUNING 10'h303
`define OFF_PHASE 10'h304
`define OFF_IN_SCALE 10'h305
`define OFF_S2_DEC 10'h306
`define OFF_S5_SCALE 10'h307
`define OFF_S5_DEC 10'h308
`define OFF_OUT_CTL 10'h309
`define OFF_FIR_DEC 10'h30a
`define OFF_COEF_BASE 10'h30b
`define OFF_TAP_COUNT 10'h30c
`define OFF_RSVD 10'h30d
`define MODE_SOFT_RESET 0
`define MODE_DIVERSITY 1
`define MODE_COMPLEX 2
`define MODE_SYNC_MASTER 3
`define MODE_RESET 8'h01
`define OSC_BYPASS 0
`define OSC_PHASE_DITHER 1
`define OSC_AMP_DITHER 2
`define IN_EXP_DIR 4
`define IN_GAIN_LSB 5
`define S2_SHIFT_MAX 3'h6
`define COEF_W 20
`define HALF_W 18
`define DIVERSITY_TAPS 9'h080
`define BYPASS_ATTEN_SHIFT 2
`endif

//--- logic/rx_regs_pkg.sv
// Purpose: Types shared by the receiver register map
// Assumes: Constants come from rx_regs_cfg.svh
// Notes: Types only
`include "rx_regs_cfg.svh"
package rx_regs_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE_REAL,
        MODE_DIVERSITY_REAL,
        MODE_SINGLE_COMPLEX,
        MODE_HALTED
    } op_mode_e;
    typedef struct packed {
        logic req;
        logic wr;
        logic [`ADDR_W-1:0] addr;
        logic [35:0] wdata;
    } ctl_req_s;
    typedef enum {
        P_IDLE,
        P_WAIT,
        P_ACK
    } par_state_e;
    typedef struct packed {
        op_mode_e mode;
        logic soft_reset;
        logic sync_master;
        logic osc_bypass;
        logic phase_dither;
        logic amp_dither;
        logic exponent_direction;
        logic [2:0] exponent_gain_offset;
        logic [2:0] stage2_shift;
        logic [4:0] stage5_shift;
        logic [8:0] taps;
    } dsp_cfg_s;
endpackage

//--- tb/ctl_host.sv
// Purpose: Host model driving the parallel and serial control ports
// Assumes: Requests launched 1 ns after the clock edge
// Notes: Released lines carry inverted values so stale data cannot pass
`timescale 1ns/100ps
module ctl_host
    import rx_regs_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Parallel port
    output logic par_mode1_o,
    output ctl_req_s par_req_o,
    input wire logic par_ready_i,
    input wire logic transfer_acknowledge_i,
    input wire logic [35:0] par_rdata_i,
    // Serial port
    output ctl_req_s ser_req_o,
    input wire logic ser_done_i,
    input wire logic [35:0] ser_rdata_i
);
    initial
    begin
        par_mode1_o = 1'b0;
        par_req_o = '0;
        ser_req_o = '0;
    end

    task automatic par_access(input logic m1, input logic wr, input logic [9:0] a,
        input logic [35:0] d, output logic [35:0] q);
        int n;
        n = 0;
        q = 'x;
        @(posedge ref_clk_i);
        #1;
        par_mode1_o = m1;
        par_req_o = '{1'b1, wr, a, d};
        // First edge still shows idle ready, so it is skipped
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (n < 40 && !(n > 1 && (m1 ? transfer_acknowledge_i : par_ready_i) === 1'b1));
        if (n < 40)
            q = par_rdata_i;
        #1;
        par_req_o = '{1'b0, ~wr, ~a, ~d};
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic ser_access(input logic wr, input logic [9:0] a, input logic [35:0] d,
        output logic [35:0] q);
        @(posedge ref_clk_i);
        #1;
        ser_req_o = '{1'b1, wr, a, d};
        @(posedge ref_clk_i);
        #1;
        ser_req_o = '{1'b0, ~wr, ~a, ~d};
        @(posedge ref_clk_i);
        q = (ser_done_i === 1'b1) ? ser_rdata_i : 'x;
        #1;
    endtask

    // Back-to-back serial writes, one per clock
    task automatic ser_burst(input logic [9:0] a, input logic [35:0] d [3]);
        @(posedge ref_clk_i);
        for (int i = 0; i < 3; i++)
        begin
            #1;
            ser_req_o = '{1'b1, 1'b1, a, d[i]};
            @(posedge ref_clk_i);
        end
        #1;
        ser_req_o = '{1'b0, 1'b0, ~a, ~d[2]};
    endtask
endmodule

//--- tb/receiver_control_register_map_tb.sv
// Purpose: Self-checking bench for the receiver register map
// Assumes: Host model owns both control ports
// Notes: Expected values come from the register map only
`timescale 1ns/100ps
module receiver_control_register_map_tb
    import rx_regs_pkg::*;
;
`include "rx_regs_cfg.svh"
    logic ref_clk_i;
    logic rst_i;
    logic par_mode1;
    ctl_req_s par_req;
    ctl_req_s ser_req;
    logic par_ready;
    logic ack;
    logic ser_done;
    logic [35:0] par_rdata;
    logic [35:0] ser_rdata;
    logic [35:0] fir_data;
    logic fir_we;
    logic [7:0] fir_addr;
    logic [7:0] coef_addr;
    logic [19:0] fir_coef;
    logic mask_load;
    dsp_cfg_s cfg;
    logic [31:0] sync_mask;
    logic [31:0] tuning;
    logic [7:0] s2_dec;
    logic [15:0] phase;
    logic [7:0] s5_dec, fir_dec, coef_base;
    logic [3:0] out_ctl;
    logic oe;
    logic in_en;
    bit pm1;
    int n_mismatch;
    int num_checks;
    logic [35:0] q;
    logic [9:0] offs [11] = '{`OFF_OSC, `OFF_TUNING, `OFF_PHASE, `OFF_S2_DEC, `OFF_S5_SCALE,
        `OFF_S5_DEC, `OFF_OUT_CTL, `OFF_FIR_DEC, `OFF_COEF_BASE, `OFF_RSVD, 10'h200};
    logic [35:0] msk [11] = '{36'h7, 36'hffffffff, 36'hffff, 36'hff, 36'h1f, 36'hff, 36'hf,
        36'hff, 36'hff, 36'h0, 36'h0};
    logic [7:0] mv [4] = '{8'h00, 8'h02, 8'h04, 8'h08};
    op_mode_e em [4] = '{MODE_SINGLE_REAL, MODE_DIVERSITY_REAL, MODE_SINGLE_COMPLEX,
        MODE_SINGLE_REAL};

    rx_regs dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .par_mode1_i(par_mode1),
        .par_req_i(par_req), .par_ready_o(par_ready), .transfer_acknowledge_o(ack),
        .par_rdata_o(par_rdata), .ser_req_i(ser_req), .ser_done_o(ser_done),
        .ser_rdata_o(ser_rdata), .fir_data_i(fir_data), .fir_data_we_i(fir_we),
        .fir_data_addr_i(fir_addr), .fir_coef_addr_i(coef_addr), .fir_coef_o(fir_coef),
        .sync_mask_load_i(mask_load), .cfg_o(cfg), .sync_mask_o(sync_mask),
        .tuning_word_o(tuning), .phase_offset_o(phase), .stage2_decimation_o(s2_dec),
        .stage5_decimation_o(s5_dec), .fir_decimation_o(fir_dec),
        .coefficient_base_o(coef_base), .output_filter_control_o(out_ctl),
        .sync_pins_oe_o(oe), .input_enable_o(in_en));

    ctl_host host_u (.ref_clk_i(ref_clk_i), .par_mode1_o(par_mode1), .par_req_o(par_req),
        .par_ready_i(par_ready), .transfer_acknowledge_i(ack), .par_rdata_i(par_rdata),
        .ser_req_o(ser_req), .ser_done_i(ser_done), .ser_rdata_i(ser_rdata));

    always #25 ref_clk_i = ~ref_clk_i;

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input bit s, input logic [9:0] a, input logic [35:0] d);
        logic [35:0] r;
        if (s)
            host_u.ser_access(1'b1, a, d, r);
        else
            host_u.par_access(pm1, 1'b1, a, d, r);
    endtask

    task automatic rc(input bit s, input logic [9:0] a, input logic [35:0] e);
        logic [35:0] r;
        if (s)
            host_u.ser_access(1'b0, a, 36'h0, r);
        else
            host_u.par_access(pm1, 1'b0, a, 36'h0, r);
        chk(r, e);
    endtask

    // Registered copies lag the register by one clock
    task automatic settle;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #2000000;
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        ref_clk_i = 1'b0;
        rst_i = 1'b1;
        fir_data = '0;
        fir_we = 1'b0;
        fir_addr = '0;
        coef_addr = '0;
        mask_load = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        chk(par_ready, 1'b1);
        chk(cfg.mode, MODE_HALTED);
        chk(cfg.soft_reset, 1'b1);
        chk(oe, 1'b0);
        chk(in_en, 1'b0);
        rc(0, `OFF_MODE, 36'h01);
        done_test("reset");
        for (int i = 0; i < 11; i++)
        begin
            wr(i[0], offs[i], '1);
            rc(!i[0], offs[i], msk[i]);
        end
        chk(tuning, 32'hffffffff);
        chk(s2_dec, 8'hff);
        chk(phase, 16'hffff);
        chk({fir_dec, s5_dec, coef_base}, 24'hffffff);
        chk({out_ctl, cfg.stage5_shift}, 9'h1ff);
        done_test("widths");
        wr(1, `OFF_IN_SCALE, 36'hfd);
        rc(0, `OFF_IN_SCALE, 36'hf5);
        settle();
        chk(cfg.stage2_shift, 3'h5);
        chk(cfg.exponent_direction, 1'b1);
        chk(cfg.exponent_gain_offset, 3'h7);
        wr(0, `OFF_IN_SCALE, 36'h07);
        settle();
        chk(cfg.stage2_shift, `S2_SHIFT_MAX);
        chk(cfg.exponent_direction, 1'b0);
        chk(cfg.exponent_gain_offset, 3'h0);
        for (int v = 0; v < 8; v++)
        begin
            wr(v[0], `OFF_OSC, v);
            settle();
            chk({cfg.amp_dither, cfg.phase_dither, cfg.osc_bypass}, v[2:0]);
        end
        done_test("scale");
        wr(1, 10'h005, 36'hfabcde123);
        rc(0, 10'h005, 36'hde123);
        coef_addr = 8'h05;
        settle();
        chk(fir_coef, 20'hde123);
        wr(0, 10'h1aa, 36'h912345678);
        rc(1, 10'h1aa, 36'h912345678);
        done_test("memories");
        for (int i = 0; i < 4; i++)
        begin
            wr(1, `OFF_MODE, mv[i]);
            settle();
            chk(cfg.mode, em[i]);
            chk(oe, i == 3);
            chk(cfg.sync_master, i == 3);
            chk(in_en, 1'b1);
            rc(0, `OFF_MODE, mv[i]);
        end
        wr(0, `OFF_TAP_COUNT, 36'hc7);
        rc(1, `OFF_TAP_COUNT, 36'hc7);
        settle();
        chk(cfg.taps, 9'h0c8);
        wr(0, `OFF_MODE, 36'h02);
        settle();
        chk(cfg.taps, `DIVERSITY_TAPS);
        fir_data = {18'h2aaaa, 18'h15555};
        fir_addr = 8'h10;
        fir_we = 1'b1;
        @(posedge ref_clk_i);
        #1;
        fir_we = 1'b0;
        rc(0, 10'h110, {18'h2aaaa, 18'h15555});
        done_test("modes");
        // Sync master going in, so the return to slave is visible
        wr(0, `OFF_MODE, 36'h08);
        rst_i = 1'b1;
        settle();
        rst_i = 1'b0;
        chk(oe, 1'b0);
        rc(0, `OFF_MODE, 36'h01);
        rc(1, 10'h1aa, 36'h912345678);
        wr(0, `OFF_SYNC_MASK, 36'h12345678);
        rc(1, `OFF_SYNC_MASK, 36'h0);
        @(posedge ref_clk_i);
        #1;
        mask_load = 1'b1;
        @(posedge ref_clk_i);
        #1;
        mask_load = 1'b0;
        rc(0, `OFF_SYNC_MASK, 36'h12345678);
        chk(sync_mask, 32'h12345678);
        done_test("reset_and_mask");
        for (int m = 0; m < 2; m++)
        begin
            pm1 = m[0];
            wr(0, `OFF_S2_DEC, 36'h0);
            fork
                host_u.par_access(pm1, 1'b0, `OFF_S2_DEC, 36'h0, q);
                host_u.ser_burst(`OFF_S2_DEC, '{36'h11, 36'h22, 36'h33});
            join
            chk(q, 36'h33);
        end
        done_test("arbitration");
        finish_test();
    end
endmodule
